// ==== logic/cpm_consts.vh ====
// Offsets, field positions, reset values and timing counts of the clock and power-mode control
`ifndef CPM_CONSTS_VH
`define CPM_CONSTS_VH
// Register byte offsets
`define CPM_CLK_SEL_OFF      12'h000
`define CPM_OSCILLATOR_SYNC_CONTROL_OFF 12'h004
`define CPM_SYNC_COUNT_OFF   12'h008
`define CPM_POWER_MODE_CONTROL_OFF     12'h00c
`define CPM_SECOND_STATUS_REGISTER_OFF      12'h010
`define CPM_REGULATOR_VOLTAGE_SELECT_OFF     12'h014
`define CPM_SEQ_STATUS_OFF   12'h018
// Field positions
`define CPM_OVR_BIT          0
`define CPM_ACTIVE_BIT       0
`define CPM_CHARGE_REGULATOR_ENABLE_BIT      1
`define CPM_BURST_SUPPLY_REGULATOR_RDY_BIT     0
// Clock source codes
`define CPM_SRC_OSC          2'h0
`define CPM_SRC_SYNC         2'h1
`define CPM_SRC_XTAL         2'h2
// Reset values
`define CPM_TRIM_RST         6'h00
`define CPM_VSEL_RST         4'h0
// Timing: nominal sync interval in clock counts at 16 MHz, 19.2 kbit/s
`define CPM_SYNC_NOMINAL     16'd1667
`define CPM_SYNC_TOL         16'd8
`define CPM_XTAL_MHZ         16
`define CPM_BAUD_X10         192
`endif

// ==== logic/cpm_sync_meas.v ====
// Sync field falling-edge interval measurement
`timescale 1ns/1ps
`default_nettype none
module cpm_sync_meas #(
   parameter CW = 16
)(
   input  wire          aclk,
   input  wire          aresetn,
   input  wire          enable,
   input  wire          rx_in,
   output reg  [CW-1:0] count_q,
   output reg           done_q
);
   reg          s1_q;
   reg          s2_q;
   reg          s3_q;
   reg          run_q;
   reg [CW-1:0] cnt_q;
   wire         fall;

   assign fall = s3_q & ~s2_q;

   // ====================================================================
   // Input synchroniser and measurement counter
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s1_q    <= 1'b1;
         s2_q    <= 1'b1;
         s3_q    <= 1'b1;
         run_q   <= 1'b0;
         cnt_q   <= {CW{1'b0}};
         count_q <= {CW{1'b0}};
         done_q  <= 1'b0;
      end
      else
      begin
         s1_q   <= rx_in;
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         done_q <= 1'b0;
         if (!enable)
         begin
            run_q <= 1'b0;
            cnt_q <= {CW{1'b0}};
         end
         else if (fall && !run_q)
         begin
            run_q <= 1'b1;
            cnt_q <= {CW{1'b0}};
         end
         else if (fall && run_q)
         begin
            run_q   <= 1'b0;
            count_q <= cnt_q + 1'b1;
            done_q  <= 1'b1;
         end
         else if (run_q && cnt_q != {CW{1'b1}})
            cnt_q <= cnt_q + 1'b1;
      end
   end
endmodule // cpm_sync_meas
`default_nettype wire

// ==== logic/cpm_top.v ====
// Clock source selection, power-up sequencing and power-mode control
// Functional notes
// - Clock from osc, synced osc or crystal
// - Software clock_source_select picks source
// - Synced mode corrects oscillator per frame
// - Measure between two sync falling edges
// - Nominal 19.2 kbit/s, within half percent
// - Sync interval count readable, near 1667
// - Override lets software write trim directly
// - Six-bit trim code adjusts oscillator
// - Buffered character mode disables synchronisation
// - Hold reset until supplies regulated
// - Core reset release starts RAM self-test
// - Then release processor reset
// - RAMs available after self-test completes
// - Power-up in quiet low-power idle mode
// - Active enable powers drivers and receive path
// - Burst regulator off until enable set
// - Ready flag when burst capacitor charged
// - Regulator output follows voltage select
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cpm_consts.vh"
module cpm_top #(
   parameter CW = 16,
   parameter TW = 6,
   parameter VW = 4
)(
   input  wire          aclk,
   input  wire          aresetn,
   // AXI4-Lite slave
   input  wire [11:0]   s_axi_awaddr,
   input  wire          s_axi_awvalid,
   output wire          s_axi_awready,
   input  wire [31:0]   s_axi_wdata,
   input  wire [3:0]    s_axi_wstrb,
   input  wire          s_axi_wvalid,
   output wire          s_axi_wready,
   output reg  [1:0]    s_axi_bresp,
   output reg           s_axi_bvalid,
   input  wire          s_axi_bready,
   input  wire [11:0]   s_axi_araddr,
   input  wire          s_axi_arvalid,
   output wire          s_axi_arready,
   output reg  [31:0]   s_axi_rdata,
   output reg  [1:0]    s_axi_rresp,
   output reg           s_axi_rvalid,
   input  wire          s_axi_rready,
   // Analog status inputs (asynchronous)
   input  wire          supplies_good,
   input  wire          bist_done_in,
   input  wire          cap_charged,
   input  wire          rx_in,
   input  wire          buffered_mode,
   // Clock and power controls
   output reg  [1:0]    clock_source_select_q,
   output reg  [TW-1:0] oscillator_trim_code_q,
   output reg           core_reset_n_q,
   output reg           bist_start_q,
   output reg           spi_enable_q,
   output reg           cpu_reset_n_q,
   output reg           ram_available_q,
   output reg           active_power_enable_q,
   output reg           charge_regulator_enable_q,
   output reg  [VW-1:0] regulator_voltage_select_q
);
   // ====================================================================
   // Declarations
   localparam [2:0] ST_POR  = 3'h0;
   localparam [2:0] ST_CORE = 3'h1;
   localparam [2:0] ST_CPU  = 3'h2;
   localparam [2:0] ST_RUN  = 3'h3;

   reg  [2:0]    st_q;
   reg  [2:0]    sg1_q;
   reg  [2:0]    sg2_q;
   reg  [1:0]    sel_q;
   reg           ovr_q;
   reg  [TW-1:0] sw_trim_q;
   reg  [TW-1:0] auto_trim_q;
   reg           rdy_q;
   reg           aw_got_q;
   reg           w_got_q;
   reg  [11:0]   awaddr_q;
   reg  [31:0]   wdata_q;
   reg  [3:0]    wstrb_q;
   reg  [31:0]   rd_d;
   reg           rd_ok;
   wire [CW-1:0] sync_cnt;
   wire          sync_done;
   wire          sync_en;
   wire          do_wr;
   wire          pwr_ok;
   wire          bist_ok;
   wire          cap_ok;
   wire          bufm;

   assign pwr_ok  = sg2_q[0];
   assign bist_ok = sg2_q[1];
   assign cap_ok  = sg2_q[2];

   // ====================================================================
   // Two-stage synchronisers for the analog status levels
   reg bm1_q;
   reg bm2_q;
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sg1_q <= 3'h0;
         sg2_q <= 3'h0;
         bm1_q <= 1'b0;
         bm2_q <= 1'b0;
      end
      else
      begin
         sg1_q <= {cap_charged, bist_done_in, supplies_good};
         sg2_q <= sg1_q;
         bm1_q <= buffered_mode;
         bm2_q <= bm1_q;
      end
   end
   assign bufm = bm2_q;

   // ====================================================================
   // Sync field measurement, only in synchronised mode
   assign sync_en = (sel_q == `CPM_SRC_SYNC) && !bufm;

   cpm_sync_meas #(.CW(CW)) u_meas (
      .aclk    (aclk),
      .aresetn (aresetn),
      .enable  (sync_en),
      .rx_in   (rx_in),
      .count_q (sync_cnt),
      .done_q  (sync_done)
   );

   // ====================================================================
   // Automatic trim: step toward nominal count, dead band of tolerance
   always @(posedge aclk)
   begin
      if (!aresetn)
         auto_trim_q <= `CPM_TRIM_RST;
      else if (sync_done && sync_en)
      begin
         // Long interval means fast oscillator: step down
         if (sync_cnt > `CPM_SYNC_NOMINAL + `CPM_SYNC_TOL
             && auto_trim_q != {1'b1, {(TW-1){1'b0}}})
            auto_trim_q <= auto_trim_q - 1'b1;
         else if (sync_cnt < `CPM_SYNC_NOMINAL - `CPM_SYNC_TOL
                  && auto_trim_q != {1'b0, {(TW-1){1'b1}}})
            auto_trim_q <= auto_trim_q + 1'b1;
      end
   end

   // ====================================================================
   // Trim and clock source outputs
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         oscillator_trim_code_q <= `CPM_TRIM_RST;
         clock_source_select_q  <= `CPM_SRC_OSC;
      end
      else
      begin
         clock_source_select_q <= sel_q;
         if (ovr_q)
            oscillator_trim_code_q <= sw_trim_q;
         else if (sel_q == `CPM_SRC_SYNC && !bufm)
            oscillator_trim_code_q <= auto_trim_q;
         else
            oscillator_trim_code_q <= `CPM_TRIM_RST;
      end
   end

   // ====================================================================
   // Power-up sequence
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_q            <= ST_POR;
         core_reset_n_q  <= 1'b0;
         bist_start_q    <= 1'b0;
         spi_enable_q    <= 1'b0;
         cpu_reset_n_q   <= 1'b0;
         ram_available_q <= 1'b0;
      end
      else
      begin
         bist_start_q <= 1'b0;
         case (st_q)
            ST_POR:
               if (pwr_ok)
               begin
                  core_reset_n_q <= 1'b1;
                  bist_start_q   <= 1'b1;
                  spi_enable_q   <= 1'b1;
                  st_q           <= ST_CORE;
               end
            ST_CORE:
            begin
               cpu_reset_n_q <= 1'b1;
               st_q          <= ST_CPU;
            end
            ST_CPU:
               if (bist_ok)
               begin
                  ram_available_q <= 1'b1;
                  st_q            <= ST_RUN;
               end
            ST_RUN:
               st_q <= ST_RUN;
            default:
               st_q <= ST_POR;
         endcase
      end
   end

   // ====================================================================
   // AXI4-Lite write channel
   assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
   assign do_wr         = aw_got_q && w_got_q && !s_axi_bvalid;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got_q <= 1'b0;
         w_got_q  <= 1'b0;
         awaddr_q <= 12'h000;
         wdata_q  <= 32'h00000000;
         wstrb_q  <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (do_wr)
         begin
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (awaddr_q)
               `CPM_CLK_SEL_OFF, `CPM_OSCILLATOR_SYNC_CONTROL_OFF,
               `CPM_POWER_MODE_CONTROL_OFF, `CPM_REGULATOR_VOLTAGE_SELECT_OFF:
                  s_axi_bresp <= 2'h0;
               default:
                  s_axi_bresp <= 2'h2;
            endcase
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // ====================================================================
   // Control registers written by software
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sel_q                      <= `CPM_SRC_OSC;
         ovr_q                      <= 1'b0;
         sw_trim_q                  <= `CPM_TRIM_RST;
         active_power_enable_q      <= 1'b0;
         charge_regulator_enable_q  <= 1'b0;
         regulator_voltage_select_q <= `CPM_VSEL_RST;
      end
      else if (do_wr && wstrb_q[0])
      begin
         case (awaddr_q)
            `CPM_CLK_SEL_OFF:
               sel_q <= wdata_q[1:0];
            `CPM_OSCILLATOR_SYNC_CONTROL_OFF:
            begin
               ovr_q     <= wdata_q[`CPM_OVR_BIT];
               sw_trim_q <= wdata_q[TW:1];
            end
            `CPM_POWER_MODE_CONTROL_OFF:
            begin
               active_power_enable_q     <= wdata_q[`CPM_ACTIVE_BIT];
               charge_regulator_enable_q <= wdata_q[`CPM_CHARGE_REGULATOR_ENABLE_BIT];
            end
            `CPM_REGULATOR_VOLTAGE_SELECT_OFF:
               regulator_voltage_select_q <= wdata_q[VW-1:0];
            default:
               sel_q <= sel_q;
         endcase
      end
   end

   // ====================================================================
   // Regulator ready flag follows charge state while enabled
   always @(posedge aclk)
   begin
      if (!aresetn)
         rdy_q <= 1'b0;
      else
         rdy_q <= charge_regulator_enable_q && cap_ok;
   end

   // ====================================================================
   // Read data multiplexer
   always @*
   begin
      rd_d  = 32'h00000000;
      rd_ok = 1'b1;
      case (s_axi_araddr)
         `CPM_CLK_SEL_OFF:       rd_d[1:0] = sel_q;
         `CPM_OSCILLATOR_SYNC_CONTROL_OFF: rd_d[TW:0] = {sw_trim_q, ovr_q};
         `CPM_SYNC_COUNT_OFF:    rd_d[CW-1:0] = sync_cnt;
         `CPM_POWER_MODE_CONTROL_OFF:
            rd_d[1:0] = {charge_regulator_enable_q, active_power_enable_q};
         `CPM_SECOND_STATUS_REGISTER_OFF:       rd_d[`CPM_BURST_SUPPLY_REGULATOR_RDY_BIT] = rdy_q;
         `CPM_REGULATOR_VOLTAGE_SELECT_OFF:      rd_d[VW-1:0] = regulator_voltage_select_q;
         `CPM_SEQ_STATUS_OFF:
            rd_d[TW+3:0] = {oscillator_trim_code_q, ram_available_q,
                            cpu_reset_n_q, core_reset_n_q, bufm};
         default:                rd_ok = 1'b0;
      endcase
   end

   // ====================================================================
   // AXI4-Lite read channel
   assign s_axi_arready = !s_axi_rvalid;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= 2'h0;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_d;
         s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
endmodule // cpm_top
`default_nettype wire

// ==== verif/cpm_sync_master_model.sv ====
// Serial bus master model sending sync field falling edges
`timescale 1ns/1ps
`default_nettype none
module cpm_sync_master_model (
   input  wire logic        aclk,
   input  wire logic        go,
   input  wire logic [15:0] gap,
   output var  logic        rx_line,
   output var  logic        busy
);
   // ==========
   // Line idles high, as pulled up
   initial
   begin
      rx_line = 1'b1;
      busy = 1'b0;
   end

   // Two falls spaced gap clocks apart, then back to idle
   always
   begin
      @(posedge aclk);
      while (!go) @(posedge aclk);
      busy <= 1'b1;
      repeat (2)
      begin
         rx_line <= 1'b0;
         repeat (gap / 2) @(posedge aclk);
         rx_line <= 1'b1;
         repeat (gap - gap / 2) @(posedge aclk);
      end
      busy <= 1'b0;
   end
endmodule // cpm_sync_master_model
`default_nettype wire

// ==== verif/cpm_top_sva.sv ====
// Checker of power-up order and register-bus answers
`timescale 1ns/1ps
`default_nettype none
module cpm_top_sva (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic supplies_good,
   input wire logic bist_done_in,
   input wire logic core_reset_n_q,
   input wire logic bist_start_q,
   input wire logic spi_enable_q,
   input wire logic cpu_reset_n_q,
   input wire logic ram_available_q,
   input wire logic active_power_enable_q,
   input wire logic charge_regulator_enable_q
);
   // ==========
   // Common clock and reset
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // ==========
   // Reset state and power-up order
   property p_quiet;
      disable iff (1'b0) !aresetn |=> !active_power_enable_q;
   endproperty
   a_quiet: assert property (p_quiet) else $error("not quiet");
   property p_burst_supply_regulator_off;
      disable iff (1'b0) !aresetn |=> !charge_regulator_enable_q;
   endproperty
   a_burst_supply_regulator_off: assert property (p_burst_supply_regulator_off) else $error("burst_supply_regulator on");
   property p_core_sup;
      $rose(core_reset_n_q) |-> $past(supplies_good, 2);
   endproperty
   a_core_sup: assert property (p_core_sup) else $error("early");
   property p_bist;
      $rose(core_reset_n_q) |-> bist_start_q && spi_enable_q;
   endproperty
   a_bist: assert property (p_bist) else $error("no self-test");
   property p_pulse;
      bist_start_q |=> !bist_start_q;
   endproperty
   a_pulse: assert property (p_pulse) else $error("start held");
   property p_cpu;
      cpu_reset_n_q |-> $past(core_reset_n_q);
   endproperty
   a_cpu: assert property (p_cpu) else $error("cpu first");
   property p_ram;
      $rose(ram_available_q) |-> $past(bist_done_in, 2) && core_reset_n_q;
   endproperty
   a_ram: assert property (p_ram) else $error("ram early");

   // ==========
   // Register bus answers
   property p_rd;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rd: assert property (p_rd) else $error("no read answer");
   property p_wr;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_wr: assert property (p_wr) else $error("no write answer");
   c_ram: cover property ($rose(ram_available_q));
   c_wr: cover property (s_axi_bvalid);
   c_rd: cover property (s_axi_rvalid);
endmodule // cpm_top_sva

bind cpm_top cpm_top_sva u_sva (
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .supplies_good, .bist_done_in, .core_reset_n_q,
   .bist_start_q, .spi_enable_q, .cpu_reset_n_q, .ram_available_q,
   .active_power_enable_q, .charge_regulator_enable_q
);
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench of clock and power-mode control
`timescale 1ns/1ps
`default_nettype none
`include "cpm_consts.vh"
module testbench;
   logic        aclk = 0, aresetn = 0, go = 0;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, rd;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0, cap_charged = 0;
   logic        supplies_good = 0, bist_done_in = 0, buffered_mode = 0;
   logic [15:0] gap = 0;
   logic [1:0]  rr, br;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, rx_in, busy;
   wire         s_axi_arready, s_axi_rvalid, core_reset_n_q;
   wire  [1:0]  s_axi_bresp, s_axi_rresp, clock_source_select_q;
   wire  [31:0] s_axi_rdata;
   wire  [5:0]  oscillator_trim_code_q;
   wire         bist_start_q, spi_enable_q, cpu_reset_n_q;
   wire         ram_available_q, active_power_enable_q;
   wire         charge_regulator_enable_q;
   wire  [3:0]  regulator_voltage_select_q;
   int          errors = 0, n_compared = 0, t = 0;

   // Device and bus master
   cpm_top uut (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .supplies_good, .bist_done_in,
      .cap_charged, .rx_in, .buffered_mode, .clock_source_select_q,
      .oscillator_trim_code_q, .core_reset_n_q, .bist_start_q,
      .spi_enable_q, .cpu_reset_n_q, .ram_available_q,
      .active_power_enable_q, .charge_regulator_enable_q,
      .regulator_voltage_select_q
   );
   cpm_sync_master_model u_bus (.aclk, .go, .gap, .rx_line(rx_in), .busy);

   always #5 aclk = ~aclk;

   // ==========
   // Helpers
   task automatic chk(input string nm, input logic [31:0] s, e);
      n_compared++;
      if (s !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
         errors++;
      end
   endtask
   task automatic test_done;
      if (errors == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // One clock with a bound on every wait
   task automatic step;
      @(posedge aclk);
      t++;
      if (t > 5000)
      begin
         errors++;
         test_done;
      end
   endtask
   task automatic axw(input logic [11:0] a, input logic [31:0] d);
      t = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         step;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      br = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic axr(input logic [11:0] a);
      t = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         step;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // One frame's sync field, then its count
   task automatic send(input logic [15:0] g);
      t = 0;
      @(posedge aclk);
      gap <= g;
      go <= 1'b1;
      step;
      go <= 1'b0;
      step;
      while (busy) step;
      axr(`CPM_SYNC_COUNT_OFF);
   endtask

   // ==========
   // Main sequence
   initial
   begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (10) @(posedge aclk);
      chk("core_rst", core_reset_n_q, 0);
      chk("active", active_power_enable_q, 0);
      chk("charge_regulator_enable", charge_regulator_enable_q, 0);
      supplies_good <= 1'b1;
      while (!core_reset_n_q) step;
      chk("spi_en", spi_enable_q, 1);
      repeat (2) step;
      chk("cpu_rst", cpu_reset_n_q, 1);
      chk("ram_early", ram_available_q, 0);
      bist_done_in <= 1'b1;
      while (!ram_available_q) step;
      // Every clock source code, ending on the synced one
      for (int j = 0; j < 3; j++)
      begin
         axw(`CPM_CLK_SEL_OFF, (j + 2) % 3);
         step;
         chk("clk_sel", clock_source_select_q, (j + 2) % 3);
      end
      chk("trim0", oscillator_trim_code_q, 0);
      send(`CPM_SYNC_NOMINAL);
      chk("count", rd, `CPM_SYNC_NOMINAL);
      chk("trim_ok", oscillator_trim_code_q, 0);
      send(16'd1676);
      chk("count_hi", rd, 1676);
      chk("trim_dn", oscillator_trim_code_q, 6'h3f);
      send(16'd1658);
      chk("trim_up", oscillator_trim_code_q, 0);
      buffered_mode <= 1'b1;
      send(16'd1700);
      chk("count_buf", rd, 1658);
      chk("trim_buf", oscillator_trim_code_q, 0);
      buffered_mode <= 1'b0;
      axw(`CPM_OSCILLATOR_SYNC_CONTROL_OFF, {25'h0, 6'h15, 1'b1});
      step;
      chk("trim_ovr", oscillator_trim_code_q, 6'h15);
      // Active mode goes first, then the burst supply
      cap_charged <= 1'b1;
      axw(`CPM_POWER_MODE_CONTROL_OFF, 32'h1);
      step;
      chk("active_on", active_power_enable_q, 1);
      chk("burst_supply_regulator_off", charge_regulator_enable_q, 0);
      axr(`CPM_SECOND_STATUS_REGISTER_OFF);
      chk("rdy_off", rd, 0);
      axw(`CPM_POWER_MODE_CONTROL_OFF, 32'h3);
      repeat (4) step;
      chk("burst_supply_regulator_on", charge_regulator_enable_q, 1);
      axr(`CPM_SECOND_STATUS_REGISTER_OFF);
      chk("rdy_on", rd, 1);
      axw(`CPM_REGULATOR_VOLTAGE_SELECT_OFF, 32'ha);
      chk("vsel_bresp", br, 2'h0);
      axr(`CPM_REGULATOR_VOLTAGE_SELECT_OFF);
      chk("vsel", regulator_voltage_select_q, 4'ha);
      chk("vsel_rd", rd, 32'ha);
      chk("vsel_rresp", rr, 2'h0);
      // Unmapped write is refused and leaves the clock source alone
      axw(12'h100, 32'h2);
      chk("unmap_bresp", br, 2'h2);
      step;
      chk("clk_keep", clock_source_select_q, 1);
      // Status word: trim, RAM ready, processor and core out of reset
      axr(`CPM_SEQ_STATUS_OFF);
      chk("seq_status", rd, 32'h15e);
      axr(12'h100);
      chk("unmap_resp", rr, 2'h2);
      chk("unmap_data", rd, 0);
      test_done;
   end
endmodule // testbench
`default_nettype wire
